/* File: rtl/scf_pkg.sv */
package scf_pkg;

	localparam int WORD_W = 32;
	localparam int CNT_W  = 6;

	// Command byte, first bit on the wire at the top
	typedef struct packed {
		logic       write_gate;
		logic       dir;
		logic [2:0] sel;
		logic       continuous_readout;
		logic [1:0] fixed_zero;
	} scf_cmd_t;

	localparam logic [7:0] CMD_RESET    = 8'h00;
	localparam logic [7:0] CMD_CONT_ON  = 8'h5c;
	localparam logic [7:0] CMD_CONT_OFF = 8'h58;
	localparam logic       DIR_READ     = 1'b1;
	localparam logic       GATE_OPEN    = 1'b0;

	localparam logic [2:0] SEL_COMM   = 3'h0;
	localparam logic [2:0] SEL_MODE   = 3'h1;
	localparam logic [2:0] SEL_CFG    = 3'h2;
	localparam logic [2:0] SEL_DATA   = 3'h3;
	localparam logic [2:0] SEL_ID     = 3'h4;
	localparam logic [2:0] SEL_OUTCTL = 3'h5;

	localparam logic [CNT_W-1:0] LEN_8      = 6'h08;
	localparam logic [CNT_W-1:0] LEN_24     = 6'h18;
	localparam logic [CNT_W-1:0] LEN_32     = 6'h20;
	localparam logic [CNT_W-1:0] CMD_TAIL   = 6'h07;
	localparam logic [CNT_W-1:0] ONES_RESET = 6'h28;
	localparam logic [CNT_W-1:0] CNT_ONE    = 6'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 6'h00;

	// Snapshot of the readable registers, frozen while a command frame reads it, not when continuous readout loads a data word
	typedef struct packed {
		logic [7:0]  status;
		logic [23:0] mode;
		logic [23:0] cfg;
		logic [23:0] data;
		logic [7:0]  id;
		logic [7:0]  output_pin_control;
		logic        append_status;
	} scf_bank_t;

	typedef struct packed {
		logic [2:0]  sel;
		logic [23:0] data;
	} scf_wr_t;

	typedef enum logic [1:0] {
		ST_CMD_WAIT,
		ST_CMD_BITS,
		ST_XFER,
		ST_CONT
	} scf_state_t;

endpackage

/* File: rtl/scf_front_end.sv */
`timescale 1ns/1ns
module scf_front_end (
	// System clock and reset
	input  wire logic        I_CLOCK,
	input  wire logic        I_RST,
	// Serial link
	input  wire logic        I_SCLK,
	input  wire logic        I_DIN,
	output logic             O_DOUT,
	// Readable register values from the converter core
	input  wire logic [7:0]  I_STATUS,
	input  wire logic [23:0] I_MODE,
	input  wire logic [23:0] I_CONFIG,
	input  wire logic [23:0] I_DATA,
	input  wire logic [7:0]  I_ID,
	input  wire logic [7:0]  I_OUTPUT_PIN_CONTROL,
	input  wire logic        I_APPEND_STATUS,
	input  wire logic        I_CONV_DONE_N,
	// Write requests and part control to the core
	output logic             O_WR_VALID,
	output logic [2:0]       O_WR_SEL,
	output logic [23:0]      O_WR_DATA,
	output logic             O_CONT_READ,
	output logic             O_PART_RESET
);

	// ---------------- Link clock domain ----------------
	scf_pkg::scf_state_t         state_reg, state_next;
	logic [scf_pkg::CNT_W-1:0]   bit_cnt_reg, cnt_next;
	logic [scf_pkg::CNT_W-1:0]   ones_cnt_reg;
	scf_pkg::scf_cmd_t           cmd_reg, cmd_next;
	logic                        cont_reg, cont_next;
	logic                        sent_reg, sent_next;
	logic                        hold_reg;
	logic [scf_pkg::WORD_W-1:0]  rx_reg;
	logic [scf_pkg::WORD_W-1:0]  tx_reg;
	logic                        dout_reg;
	logic                        rdy_meta_reg, rdy_n_sync_reg;
	scf_pkg::scf_wr_t            wr_reg;
	logic                        wr_tgl_reg;
	logic                        rst_tgl_reg;

	logic [7:0]                  cmd_bits;
	scf_pkg::scf_cmd_t           cmd_byte;
	logic                        ones_hit;
	logic                        cmd_last;
	logic                        xfer_last;
	logic                        cont_start;
	logic                        cont_off;
	logic                        load_read;

	// ---------------- System clock domain ----------------
	scf_pkg::scf_bank_t          bank_reg;
	logic                        hold_meta_reg, hold_sync_reg;
	logic                        wr_meta_reg, wr_sync_reg, wr_prev_reg;
	logic                        rs_meta_reg, rs_sync_reg, rs_prev_reg;
	logic                        cont_meta_reg, cont_sync_reg;
	logic                        wr_valid_reg;
	scf_pkg::scf_wr_t            wr_out_reg;
	logic                        part_rst_reg;

	function automatic logic [scf_pkg::CNT_W-1:0] xfer_len(
		input logic [2:0] sel,
		input logic       append
	);
		logic [scf_pkg::CNT_W-1:0] n;
		n = scf_pkg::LEN_8;
		case (sel)
			scf_pkg::SEL_MODE,
			scf_pkg::SEL_CFG: n = scf_pkg::LEN_24;
			scf_pkg::SEL_DATA: begin
				n = append ? scf_pkg::LEN_32 : scf_pkg::LEN_24;
			end
			default: n = scf_pkg::LEN_8;
		endcase
		return n;
	endfunction

	// Word left aligned so the top bit leaves first
	function automatic logic [scf_pkg::WORD_W-1:0] read_word(
		input logic [2:0]         sel,
		input scf_pkg::scf_bank_t b
	);
		logic [scf_pkg::WORD_W-1:0] w;
		w = '0;
		case (sel)
			scf_pkg::SEL_COMM:   w = {b.status, 24'h000000};
			scf_pkg::SEL_MODE:   w = {b.mode, 8'h00};
			scf_pkg::SEL_CFG:    w = {b.cfg, 8'h00};
			scf_pkg::SEL_DATA: begin
				w = b.append_status ? {b.data, b.status}
				                    : {b.data, 8'h00};
			end
			scf_pkg::SEL_ID:     w = {b.id, 24'h000000};
			scf_pkg::SEL_OUTCTL: w = {b.output_pin_control, 24'h000000};
			default:             w = '0;
		endcase
		return w;
	endfunction

	// Gate bit was 0, so the assembled byte has a 0 on top
	assign cmd_bits   = {scf_pkg::GATE_OPEN, rx_reg[5:0], I_DIN};
	assign cmd_byte   = scf_pkg::scf_cmd_t'(cmd_bits);
	assign ones_hit   = I_DIN &&
	                    (ones_cnt_reg == scf_pkg::ONES_RESET - scf_pkg::CNT_ONE);
	assign cmd_last   = (state_reg == scf_pkg::ST_CMD_BITS) &&
	                    (bit_cnt_reg == scf_pkg::CNT_ONE);
	assign xfer_last  = (state_reg == scf_pkg::ST_XFER) &&
	                    (bit_cnt_reg == scf_pkg::CNT_ONE);
	assign cont_start = (state_reg == scf_pkg::ST_CONT) &&
	                    (bit_cnt_reg == scf_pkg::CNT_ZERO) &&
	                    !rdy_n_sync_reg && !sent_reg;
	assign cont_off   = (state_reg == scf_pkg::ST_CONT) && !rdy_n_sync_reg &&
	                    ({rx_reg[6:0], I_DIN} == scf_pkg::CMD_CONT_OFF);
	assign load_read  = cmd_last && (cmd_byte.dir == scf_pkg::DIR_READ) &&
	                    (cmd_bits != scf_pkg::CMD_CONT_ON);

	// Conversion-done level into the link domain
	always_ff @(posedge I_SCLK or posedge I_RST) begin
		if (I_RST) begin
			rdy_meta_reg   <= 1'b1;
			rdy_n_sync_reg <= 1'b1;
		end else begin
			rdy_meta_reg   <= I_CONV_DONE_N;
			rdy_n_sync_reg <= rdy_meta_reg;
		end
	end

	// Run of ones on DIN, saturating
	always_ff @(posedge I_SCLK or posedge I_RST) begin
		if (I_RST) begin
			ones_cnt_reg <= scf_pkg::CNT_ZERO;
		end else if (!I_DIN) begin
			ones_cnt_reg <= scf_pkg::CNT_ZERO;
		end else if (ones_cnt_reg != scf_pkg::ONES_RESET) begin
			ones_cnt_reg <= ones_cnt_reg + scf_pkg::CNT_ONE;
		end
	end

	always_comb begin
		state_next = state_reg;
		cnt_next   = bit_cnt_reg;
		cmd_next   = cmd_reg;
		cont_next  = cont_reg;
		sent_next  = sent_reg;
		if (ones_hit) begin
			state_next = scf_pkg::ST_CMD_WAIT;
			cnt_next   = scf_pkg::CNT_ZERO;
			cmd_next   = scf_pkg::scf_cmd_t'(scf_pkg::CMD_RESET);
			cont_next  = 1'b0;
			sent_next  = 1'b0;
		end else begin
			case (state_reg)
				scf_pkg::ST_CMD_WAIT: begin
					if (I_DIN == scf_pkg::GATE_OPEN) begin
						state_next = scf_pkg::ST_CMD_BITS;
						cnt_next   = scf_pkg::CMD_TAIL;
					end
				end
				scf_pkg::ST_CMD_BITS: begin
					cnt_next = bit_cnt_reg - scf_pkg::CNT_ONE;
					if (cmd_last) begin
						cmd_next = cmd_byte;
						if (cmd_bits == scf_pkg::CMD_CONT_ON) begin
							state_next = scf_pkg::ST_CONT;
							cnt_next   = scf_pkg::CNT_ZERO;
							cont_next  = 1'b1;
							sent_next  = 1'b0;
						end else if (cmd_byte.dir == scf_pkg::DIR_READ ||
						             cmd_byte.sel != scf_pkg::SEL_COMM) begin
							state_next = scf_pkg::ST_XFER;
							cnt_next   = xfer_len(cmd_byte.sel,
							                      bank_reg.append_status);
						end else begin
							state_next = scf_pkg::ST_CMD_WAIT;
						end
					end
				end
				scf_pkg::ST_XFER: begin
					cnt_next = bit_cnt_reg - scf_pkg::CNT_ONE;
					if (xfer_last) begin
						state_next = cont_reg ? scf_pkg::ST_CONT
						                      : scf_pkg::ST_CMD_WAIT;
					end
				end
				scf_pkg::ST_CONT: begin
					if (cont_off) begin
						state_next = scf_pkg::ST_CMD_WAIT;
						cnt_next   = scf_pkg::CNT_ZERO;
						cont_next  = 1'b0;
					end else if (bit_cnt_reg != scf_pkg::CNT_ZERO) begin
						cnt_next = bit_cnt_reg - scf_pkg::CNT_ONE;
						if (bit_cnt_reg == scf_pkg::CNT_ONE) begin
							sent_next = 1'b1;
						end
					end else if (cont_start) begin
						cnt_next = xfer_len(scf_pkg::SEL_DATA,
						                    bank_reg.append_status);
					end else if (rdy_n_sync_reg) begin
						sent_next = 1'b0;
					end
				end
				default: state_next = scf_pkg::ST_CMD_WAIT;
			endcase
		end
	end

	// Sequencer state; reset lands waiting for a command
	always_ff @(posedge I_SCLK or posedge I_RST) begin
		if (I_RST) begin
			state_reg   <= scf_pkg::ST_CMD_WAIT;
			bit_cnt_reg <= scf_pkg::CNT_ZERO;
			cmd_reg     <= scf_pkg::scf_cmd_t'(scf_pkg::CMD_RESET);
			cont_reg    <= 1'b0;
			sent_reg    <= 1'b0;
			hold_reg    <= 1'b0;
		end else begin
			state_reg   <= state_next;
			bit_cnt_reg <= cnt_next;
			cmd_reg     <= cmd_next;
			cont_reg    <= cont_next;
			sent_reg    <= sent_next;
			// Freeze the bank during command bits and transfers, and while a continuous word shifts out
			hold_reg    <= (state_next == scf_pkg::ST_CMD_BITS) ||
			               (state_next == scf_pkg::ST_XFER) ||
			               (cnt_next != scf_pkg::CNT_ZERO);
		end
	end

	// Shift registers, top bit first both ways
	always_ff @(posedge I_SCLK or posedge I_RST) begin
		if (I_RST) begin
			rx_reg <= '0;
			tx_reg <= '0;
		end else begin
			rx_reg <= {rx_reg[scf_pkg::WORD_W-2:0], I_DIN};
			if (load_read) begin
				tx_reg <= read_word(cmd_byte.sel, bank_reg);
			end else if (cont_start && !cont_off) begin
				tx_reg <= read_word(scf_pkg::SEL_DATA, bank_reg);
			end else begin
				tx_reg <= {tx_reg[scf_pkg::WORD_W-2:0], 1'b0};
			end
		end
	end

	// Completed writes and part reset leave as toggles
	always_ff @(posedge I_SCLK or posedge I_RST) begin
		if (I_RST) begin
			wr_reg      <= '0;
			wr_tgl_reg  <= 1'b0;
			rst_tgl_reg <= 1'b0;
		end else begin
			if (xfer_last && cmd_reg.dir != scf_pkg::DIR_READ && !ones_hit) begin
				wr_reg     <= {cmd_reg.sel, rx_reg[22:0], I_DIN};
				wr_tgl_reg <= !wr_tgl_reg;
			end
			if (ones_hit) begin
				rst_tgl_reg <= !rst_tgl_reg;
			end
		end
	end

	// Output bit changes on the falling edge
	always_ff @(negedge I_SCLK or posedge I_RST) begin
		if (I_RST) begin
			dout_reg <= 1'b0;
		end else begin
			dout_reg <= tx_reg[scf_pkg::WORD_W-1];
		end
	end

	assign O_DOUT = dout_reg;

	// ---------------- System domain logic ----------------
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			hold_meta_reg <= 1'b0;
			hold_sync_reg <= 1'b0;
			wr_meta_reg   <= 1'b0;
			wr_sync_reg   <= 1'b0;
			wr_prev_reg   <= 1'b0;
			rs_meta_reg   <= 1'b0;
			rs_sync_reg   <= 1'b0;
			rs_prev_reg   <= 1'b0;
			cont_meta_reg <= 1'b0;
			cont_sync_reg <= 1'b0;
		end else begin
			hold_meta_reg <= hold_reg;
			hold_sync_reg <= hold_meta_reg;
			wr_meta_reg   <= wr_tgl_reg;
			wr_sync_reg   <= wr_meta_reg;
			wr_prev_reg   <= wr_sync_reg;
			rs_meta_reg   <= rst_tgl_reg;
			rs_sync_reg   <= rs_meta_reg;
			rs_prev_reg   <= rs_sync_reg;
			cont_meta_reg <= cont_reg;
			cont_sync_reg <= cont_meta_reg;
		end
	end

	// Readable values, held still while a command frame reads them, not when continuous readout loads a word
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			bank_reg <= '0;
		end else if (!hold_sync_reg) begin
			bank_reg <= '{status:             I_STATUS,
			              mode:               I_MODE,
			              cfg:                I_CONFIG,
			              data:               I_DATA,
			              id:                 I_ID,
			              output_pin_control: I_OUTPUT_PIN_CONTROL,
			              append_status:      I_APPEND_STATUS};
		end
	end

	// Write request and part reset pulses
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			wr_valid_reg <= 1'b0;
			wr_out_reg   <= '0;
			part_rst_reg <= 1'b0;
		end else begin
			wr_valid_reg <= wr_sync_reg != wr_prev_reg;
			if (wr_sync_reg != wr_prev_reg) begin
				wr_out_reg <= wr_reg;
			end
			part_rst_reg <= rs_sync_reg != rs_prev_reg;
		end
	end

	assign O_WR_VALID   = wr_valid_reg;
	assign O_WR_SEL     = wr_out_reg.sel;
	assign O_WR_DATA    = wr_out_reg.data;
	assign O_CONT_READ  = cont_sync_reg;
	assign O_PART_RESET = part_rst_reg;

endmodule

/* File: dv/scf_front_end_chk.sv */
`timescale 1ns/1ns
module scf_front_end_chk (
	// Clock and reset
	input wire logic        I_CLOCK,
	input wire logic        I_RST,
	// Watched outputs
	input wire logic        O_DOUT,
	input wire logic        O_WR_VALID,
	input wire logic [2:0]  O_WR_SEL,
	input wire logic [23:0] O_WR_DATA,
	input wire logic        O_CONT_READ,
	input wire logic        O_PART_RESET
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	sequence s_wr_quiet;
		!O_WR_VALID;
	endsequence
	sequence s_prst_quiet;
		!O_PART_RESET [*8];
	endsequence

	a_wr_single_pulse: assert property (O_WR_VALID |=> s_wr_quiet)
		else $error("write strobe longer than one cycle");
	a_wr_fields_held: assert property (!O_WR_VALID |->
		$stable(O_WR_SEL) && $stable(O_WR_DATA))
		else $error("write fields moved without a strobe");
	a_wr_not_cmd: assert property (O_WR_VALID |->
		O_WR_SEL != scf_pkg::SEL_COMM)
		else $error("command byte passed to the core");
	a_prst_one_pulse: assert property (O_PART_RESET |=> s_prst_quiet)
		else $error("part reset pulse repeated");
	a_prst_clears_cont: assert property (O_PART_RESET |->
		##[0:8] !O_CONT_READ)
		else $error("continuous readout survived part reset");
	a_prst_no_write: assert property (O_PART_RESET |-> !O_WR_VALID)
		else $error("write issued with part reset");
	a_release_idle: assert property ($fell(I_RST) |-> !O_DOUT &&
		!O_CONT_READ && !O_WR_VALID && O_WR_SEL == 3'h0)
		else $error("outputs not idle after reset");
	a_cont_no_write: assert property ($rose(O_CONT_READ) |-> s_wr_quiet)
		else $error("continuous enable issued a core write");
endmodule

bind scf_front_end scf_front_end_chk scf_front_end_chk_i (
	.I_CLOCK      (I_CLOCK),
	.I_RST        (I_RST),
	.O_DOUT       (O_DOUT),
	.O_WR_VALID   (O_WR_VALID),
	.O_WR_SEL     (O_WR_SEL),
	.O_WR_DATA    (O_WR_DATA),
	.O_CONT_READ  (O_CONT_READ),
	.O_PART_RESET (O_PART_RESET)
);

/* File: dv/scf_host.sv */
`timescale 1ns/1ns
module scf_host (
	// Serial link
	output logic      o_sclk,
	output logic      o_din,
	input  wire logic i_dout
);
	// Clock idles high, data idles high between frames
	initial begin
		o_sclk = 1'h1;
		o_din  = 1'h1;
	end

	// Shifts out the low n bits of tx, top bit first; DOUT is sampled on each rising edge
	task automatic xfer(input logic [63:0] tx, input int n,
		output logic [31:0] rx);
		rx = 32'h0;
		#3;
		for (int i = n - 1; i >= 0; i--) begin
			o_sclk = 1'h0;
			o_din  = tx[i];
			#32;
			o_sclk = 1'h1;
			rx = {rx[30:0], i_dout};
			#32;
		end
		o_din = 1'h1;
	endtask
endmodule

/* File: dv/scf_front_end_tb_top.sv */
`timescale 1ns/1ns
module scf_front_end_tb_top;
	typedef struct {
		logic [7:0]  c;
		int          n;
		logic [31:0] v;
	} scf_row_t;

	logic        clk, rst, sclk, din, dout, append, done_n;
	logic        wr_valid, cont, prst;
	logic [2:0]  wr_sel, seen_sel;
	logic [23:0] wr_data, seen_data, mode_v, cfg_v, data_v;
	logic [7:0]  status_v, id_v, pin_v;
	logic [31:0] rx, mask;
	int          n_fail, samples_checked, n_wr, n_prst, base;
	scf_row_t    rows [14];

	scf_front_end scf_front_end_i (
		.I_CLOCK(clk), .I_RST(rst), .I_SCLK(sclk), .I_DIN(din),
		.O_DOUT(dout), .I_STATUS(status_v), .I_MODE(mode_v),
		.I_CONFIG(cfg_v), .I_DATA(data_v), .I_ID(id_v),
		.I_OUTPUT_PIN_CONTROL(pin_v), .I_APPEND_STATUS(append),
		.I_CONV_DONE_N(done_n), .O_WR_VALID(wr_valid), .O_WR_SEL(wr_sel),
		.O_WR_DATA(wr_data), .O_CONT_READ(cont), .O_PART_RESET(prst));
	scf_host scf_host_i (.o_sclk(sclk), .o_din(din), .i_dout(dout));

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		if (wr_valid === 1'h1) begin
			n_wr++;
			seen_sel = wr_sel;
			seen_data = wr_data;
		end
		if (prst === 1'h1)
			n_prst++;
	end

	task automatic stop_test();
		$display("checked %0d, wrong %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Bounded wait: 0 write, 1 cont on, 2 cont off, 3 part reset
	task automatic await(input int k);
		for (int t = 0; t < 800; t++) begin
			@(negedge clk);
			if (k == 0 && n_wr != base) return;
			if (k == 1 && cont === 1'h1) return;
			if (k == 2 && cont === 1'h0) return;
			if (k == 3 && n_prst != base) return;
		end
		n_fail++;
		$display("wrong value at %0t: wait %0d ran out", $time, k);
		stop_test();
	endtask

	initial begin
		{n_fail, samples_checked, n_wr, n_prst, base} = '0;
		{rst, append, done_n} = 3'h5;
		{status_v, id_v, pin_v} = {8'ha5, 8'h5a, 8'h3c};
		{mode_v, cfg_v, data_v} = {24'h123456, 24'h89abcd, 24'hc3c3c3};
		repeat (3) @(negedge clk);
		rst = 1'h0;
		chk({dout, wr_valid, cont, prst, wr_sel, 8'(wr_data)}, 32'h0);
		$display("test reset done");
		repeat (4) @(negedge clk);
		rows = '{'{8'h40, 8, 32'(status_v)}, '{8'h48, 24, 32'(mode_v)},
			'{8'h50, 24, 32'(cfg_v)}, '{8'h58, 24, 32'(data_v)},
			'{8'h60, 8, 32'(id_v)}, '{8'h68, 8, 32'(pin_v)},
			'{8'h70, 8, 32'h0}, '{8'h78, 8, 32'h0},
			'{8'h08, 24, 32'h0f1e2d}, '{8'h10, 24, 32'ha1b2c3},
			'{8'h20, 8, 32'h81}, '{8'h28, 8, 32'h7e},
			'{8'h30, 8, 32'h99}, '{8'h38, 8, 32'h66}};
		foreach (rows[k]) begin
			base = n_wr;
			scf_host_i.xfer((64'(rows[k].c) << rows[k].n) | 64'(rows[k].v),
				rows[k].n + 8, rx);
			mask = (rows[k].n == 8) ? 32'hff : 32'hffffff;
			if (rows[k].c[6]) begin
				chk(rx, rows[k].v);
			end else begin
				await(0);
				chk(32'(seen_sel), 32'(rows[k].c[5:3]));
				chk(32'(seen_data) & mask, rows[k].v);
			end
		end
		$display("test rows done");
		@(negedge clk);
		append = 1'h1;
		repeat (4) @(negedge clk);
		scf_host_i.xfer({8'h58, 32'h0}, 40, rx);
		chk(rx, {data_v, status_v});
		@(negedge clk);
		append = 1'h0;
		base = n_wr;
		scf_host_i.xfer(64'h0, 8, rx);
		scf_host_i.xfer({8'h40, 8'h0}, 16, rx);
		chk(rx, 32'(status_v));
		chk(32'(n_wr), 32'(base));
		$display("test command byte done");
		@(negedge clk);
		mode_v = 24'h654321;
		repeat (4) @(negedge clk);
		scf_host_i.xfer({12'hf48, 24'h0}, 36, rx);
		chk(rx, 32'(mode_v));
		base = n_prst;
		scf_host_i.xfer({39{1'h1}}, 39, rx);
		scf_host_i.xfer({8'h48, 24'h0}, 32, rx);
		chk(rx, 32'(mode_v));
		chk(32'(n_prst), 32'(base));
		$display("test gate and 39 ones done");
		scf_host_i.xfer(64'h5c, 8, rx);
		await(1);
		done_n = 1'h0;
		// Two sync edges, one start edge, then the data word
		scf_host_i.xfer(64'h0, 27, rx);
		chk(rx, 32'(data_v));
		scf_host_i.xfer(64'h0058, 16, rx);
		await(2);
		done_n = 1'h1;
		$display("test continuous done");
		scf_host_i.xfer(64'h5c, 8, rx);
		await(1);
		// Exit byte with conversion not done is ignored
		scf_host_i.xfer(64'h58, 8, rx);
		repeat (8) @(negedge clk);
		chk(32'(cont), 32'h1);
		base = n_prst;
		scf_host_i.xfer({40{1'h1}}, 40, rx);
		await(3);
		await(2);
		scf_host_i.xfer({8'h50, 24'h0}, 32, rx);
		chk(rx, 32'(cfg_v));
		$display("test part reset done");
		scf_host_i.xfer(64'h5c, 8, rx);
		await(1);
		rst = 1'h1;
		repeat (3) @(negedge clk);
		rst = 1'h0;
		chk(32'({dout, wr_valid, cont, prst, wr_sel, wr_data}), 32'h0);
		repeat (4) @(negedge clk);
		scf_host_i.xfer({8'h48, 24'h0}, 32, rx);
		chk(rx, 32'(mode_v));
		$display("test mid-run reset done");
		stop_test();
	end
endmodule
